// ===== design/clkgen_pkg.sv
// package: register map, fields and reset values for the clock-generation control block
package clkgen_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [11:0] PLL_CONTROL_OFF = 12'h000;
  localparam logic [11:0] MODE_CTRL_OFF   = 12'h004;
  localparam logic [11:0] STATUS_OFF      = 12'h008;
  localparam logic [11:0] NMI_COUNT_OFF   = 12'h00C;

  // ****************************************
  // pll_control_reg fields
  // ****************************************
  localparam int          PLL_ON_POS  = 0;
  localparam int          MULT_LSB    = 8;
  localparam int          DIV_LSB     = 16;
  localparam int          FACTOR_W    = 8;
  localparam logic [7:0]  MULT_RST    = 8'h01;
  localparam logic [7:0]  DIV_RST     = 8'h01;

  // ****************************************
  // mode and status fields
  // ****************************************
  localparam int          ABE_POS        = 0;
  localparam int          NMI_PEND_POS   = 0;
  localparam int          ALIGN_REF_POS  = 1;
  localparam int          PLL_ACT_POS    = 2;
  localparam int          ASYNC_ACT_POS  = 3;
  localparam int          NMI_CNT_W      = 16;

  // ****************************************
  // timing
  // ****************************************
  localparam int          SYNC_STAGES    = 2;
  localparam int          CLK_MHZ        = 20;
  localparam int          ASYNC_LIMIT_MHZ = 100;

  typedef enum logic [1:0] {
    CLK_DIV2   = 2'b00,
    CLK_LOOP   = 2'b01,
    CLK_BYPASS = 2'b10
  } clk_src_t;

endpackage

// ===== design/core_clock_output_gen.sv
// core clock output generator: half-rate toggle or loop-derived clock
`timescale 1ns/10ps
module core_clock_output_gen (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // control
  input  wire clkgen_pkg::clk_src_t src,
  input  wire logic [7:0]         mult,
  input  wire logic [7:0]         div,
  // output
  output logic                    clk_out
);
  import clkgen_pkg::*;

  // ****************************************
  // loop model: toggles every div/mult pclk cycles
  // ****************************************
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       tog_r;
  logic       tog_nxt;
  logic [7:0] period;

  always_comb begin
    period  = (mult == 8'h00) ? div : (div / mult);
    if (period == 8'h00) begin
      period = 8'h01;
    end
    cnt_nxt = cnt_r;
    tog_nxt = tog_r;
    case (src)
      CLK_DIV2: begin
        tog_nxt = ~tog_r;
        cnt_nxt = 8'h00;
      end
      CLK_LOOP, CLK_BYPASS: begin
        if (cnt_r + 8'h01 >= period) begin
          cnt_nxt = 8'h00;
          tog_nxt = ~tog_r;
        end else begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      default: begin
        tog_nxt = ~tog_r;
        cnt_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      tog_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tog_r <= tog_nxt;
    end
  end

  assign clk_out = tog_r;
endmodule

// ===== design/pll_clock_ctrl.sv
// clock-generation control: loop enable, clock output, arbitration mode, nmi sync
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module pll_clock_ctrl (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        pll_enable_strap,
  input  wire logic        nmi_n,
  input  wire logic        bus_busy_n,
  input  wire logic        bus_grant_n,
  // outputs
  output logic             core_clock_output,
  output logic             nmi_request,
  output logic             async_arb_mode,
  output logic             bus_busy_sync,
  output logic             bus_grant_sync
);
  import clkgen_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic strap_s1_r, strap_s2_r;
  logic nmi_s1_r, nmi_s2_r, nmi_prev_r;
  logic bb_s1_r, bb_s2_r, bg_s1_r, bg_s2_r;
  logic run_r;

  // strap path runs under reset so its level is settled at release
  always_ff @(posedge pclk) begin
    strap_s1_r <= pll_enable_strap;
    strap_s2_r <= strap_s1_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_s1_r   <= 1'b1;
      nmi_s2_r   <= 1'b1;
      nmi_prev_r <= 1'b1;
      bb_s1_r    <= 1'b1;
      bb_s2_r    <= 1'b1;
      bg_s1_r    <= 1'b1;
      bg_s2_r    <= 1'b1;
    end else begin
      nmi_s1_r   <= nmi_n;
      nmi_s2_r   <= nmi_s1_r;
      nmi_prev_r <= nmi_s2_r;
      bb_s1_r    <= bus_busy_n;
      bb_s2_r    <= bb_s1_r;
      bg_s1_r    <= bus_grant_n;
      bg_s2_r    <= bg_s1_r;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  logic       pll_on_r, pll_on_nxt;
  logic       strap_taken_r, strap_taken_nxt;
  logic [7:0] mult_r, mult_nxt;
  logic [7:0] div_r, div_nxt;
  logic       abe_r, abe_nxt;
  logic       wr_en, rd_en;
  logic       addr_ok;

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == PLL_CONTROL_OFF) || (a == MODE_CTRL_OFF) ||
                 (a == STATUS_OFF) || (a == NMI_COUNT_OFF);
  endfunction

  assign addr_ok = known_addr(paddr);
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && penable && !pwrite;

  always_comb begin
    pll_on_nxt      = pll_on_r;
    strap_taken_nxt = strap_taken_r;
    mult_nxt        = mult_r;
    div_nxt         = div_r;
    abe_nxt         = abe_r;
    if (!strap_taken_r) begin
      pll_on_nxt      = strap_s2_r;
      strap_taken_nxt = 1'b1;
    end else if (wr_en && paddr == PLL_CONTROL_OFF) begin
      pll_on_nxt = pwdata[PLL_ON_POS];
      mult_nxt   = pwdata[MULT_LSB +: FACTOR_W];
      div_nxt    = pwdata[DIV_LSB +: FACTOR_W];
    end
    if (wr_en && paddr == MODE_CTRL_OFF) begin
      abe_nxt = pwdata[ABE_POS];
    end
  end

  // loop enable cleared while reset holds, strap level caught in the first cycle after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_on_r      <= 1'b0;
      strap_taken_r <= 1'b0;
      mult_r        <= MULT_RST;
      div_r         <= DIV_RST;
      abe_r         <= 1'b0;
      run_r         <= 1'b0;
    end else begin
      pll_on_r      <= pll_on_nxt;
      strap_taken_r <= strap_taken_nxt;
      mult_r        <= mult_nxt;
      div_r         <= div_nxt;
      abe_r         <= abe_nxt;
      run_r         <= strap_taken_r;
    end
  end

  // ****************************************
  // clock source selection
  // ****************************************
  clk_src_t src;
  logic     clk_raw;
  logic     aligned;

  always_comb begin
    aligned = 1'b0;
    if (!pll_on_r) begin
      src = CLK_DIV2;
    end else if (mult_r == 8'h01 && div_r == 8'h01) begin
      src     = CLK_BYPASS;
      aligned = 1'b1;
    end else begin
      src = CLK_LOOP;
    end
  end

  core_clock_output_gen u_core_clock_output (
    .pclk    (pclk),
    .presetn (presetn),
    .src     (src),
    .mult    (mult_r),
    .div     (div_r),
    .clk_out (clk_raw)
  );

  // ****************************************
  // nmi edge, arbitration, output flops
  // ****************************************
  logic        nmi_pend_r, nmi_pend_nxt;
  logic [15:0] nmi_cnt_r, nmi_cnt_nxt;
  logic        nmi_fall;
  logic        nmi_clr;
  logic        clk_out_nxt;
  logic        nmi_req_nxt;
  logic        async_nxt;
  logic        busy_nxt;
  logic        grant_nxt;

  assign nmi_fall = run_r && nmi_prev_r && !nmi_s2_r;
  assign nmi_clr  = wr_en && paddr == STATUS_OFF && pwdata[NMI_PEND_POS];

  always_comb begin
    nmi_pend_nxt = nmi_pend_r;
    nmi_cnt_nxt  = nmi_cnt_r;
    if (nmi_clr) begin
      nmi_pend_nxt = 1'b0;
    end
    if (nmi_fall) begin
      nmi_pend_nxt = 1'b1;
      nmi_cnt_nxt  = nmi_cnt_r + 16'h0001;
    end
    clk_out_nxt = clk_raw;
    nmi_req_nxt = nmi_fall;
    async_nxt   = abe_r;
    busy_nxt    = bus_busy_sync;
    grant_nxt   = bus_grant_sync;
    // async mode passes the pins through the two-stage synchroniser and the output flop only
    if (abe_r || core_clock_output) begin
      busy_nxt  = bb_s2_r;
      grant_nxt = bg_s2_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_pend_r        <= 1'b0;
      nmi_cnt_r         <= 16'h0000;
      core_clock_output <= 1'b0;
      nmi_request       <= 1'b0;
      async_arb_mode    <= 1'b0;
      bus_busy_sync     <= 1'b1;
      bus_grant_sync    <= 1'b1;
    end else begin
      nmi_pend_r        <= nmi_pend_nxt;
      nmi_cnt_r         <= nmi_cnt_nxt;
      core_clock_output <= clk_out_nxt;
      nmi_request       <= nmi_req_nxt;
      async_arb_mode    <= async_nxt;
      bus_busy_sync     <= busy_nxt;
      bus_grant_sync    <= grant_nxt;
    end
  end

  // ****************************************
  // apb read and answer
  // ****************************************
  logic [31:0] rd_nxt;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      PLL_CONTROL_OFF: begin
        rd_nxt[PLL_ON_POS]              = pll_on_r;
        rd_nxt[MULT_LSB +: FACTOR_W]    = mult_r;
        rd_nxt[DIV_LSB +: FACTOR_W]     = div_r;
      end
      MODE_CTRL_OFF: begin
        rd_nxt[ABE_POS] = abe_r;
      end
      STATUS_OFF: begin
        rd_nxt[NMI_PEND_POS]  = nmi_pend_r;
        rd_nxt[ALIGN_REF_POS] = aligned;
        rd_nxt[PLL_ACT_POS]   = pll_on_r;
        rd_nxt[ASYNC_ACT_POS] = abe_r;
      end
      NMI_COUNT_OFF: begin
        rd_nxt[NMI_CNT_W-1:0] = nmi_cnt_r;
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;

  // read data caught in setup, held through access, then cleared
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      prdata_nxt = rd_nxt;
    end else if (rd_en) begin
      prdata_nxt = prdata;
    end
    pready_nxt  = psel && !penable;
    pslverr_nxt = pready_nxt && !addr_ok;
  end

  // zero wait states: pready high throughout access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= prdata_nxt;
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

endmodule

// ===== verification/pll_clock_ctrl_monitor.sv
// checker of the clock control ports
`timescale 1ns/10ps
module pll_clock_ctrl_monitor (
  // clock, reset, apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // pins
  input wire logic        pll_enable_strap,
  input wire logic        nmi_n,
  input wire logic        core_clock_output,
  input wire logic        nmi_request,
  input wire logic        async_arb_mode,
  input wire logic        bus_busy_n,
  input wire logic        bus_grant_n,
  input wire logic        bus_busy_sync,
  input wire logic        bus_grant_sync
);
  logic       acc, wr_ctl, on_m, fast_m, mode_m;
  logic [2:0] run_r;
  assign acc    = psel && penable && pready;
  assign wr_ctl = acc && pwrite && paddr == 12'h000;
  // mirror of loop state, strap copied while reset is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_m   <= pll_enable_strap;
      fast_m <= 1'b1;
      mode_m <= 1'b0;
      run_r  <= 3'h0;
    end else begin
      if (wr_ctl) begin
        on_m   <= pwdata[0];
        fast_m <= pwdata[23:8] == 16'h0101;
      end
      if (acc && pwrite && paddr == 12'h004)
        mode_m <= pwdata[0];
      run_r <= wr_ctl ? 3'h0 : run_r + {2'h0, run_r != 3'h7};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence nmi_fall;
    $fell(nmi_n) && run_r > 3'h2;
  endsequence
  sequence nmi_pulse;
    nmi_request ##1 !nmi_request;
  endsequence
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("no ready");
  clk_runs_a: assert property (run_r > 3'h3 |-> ##[1:520] $changed(core_clock_output))
    else $error("clock stuck");
  clk_align_a: assert property (run_r > 3'h3 && on_m && fast_m |->
      $changed(core_clock_output))
    else $error("clock not at reference rate");
  clk_half_a: assert property (run_r > 3'h3 && !on_m |-> $changed(core_clock_output))
    else $error("clock not half rate");
  mode_copy_a: assert property (acc && pwrite && paddr == 12'h004 |=>
      ##1 async_arb_mode == mode_m)
    else $error("mode not applied");
  pll_read_a: assert property (acc && !pwrite && paddr == 12'h000 |->
      prdata[0] == on_m)
    else $error("loop bit wrong");
  nmi_pulse_a: assert property (nmi_fall |-> ##3 nmi_pulse)
    else $error("nmi pulse missing");
  nmi_cause_a: assert property (nmi_request |-> $past(nmi_n, 4) && !$past(nmi_n, 3))
    else $error("nmi without fall");
  bus_async_a: assert property (async_arb_mode |->
      bus_busy_sync == $past(bus_busy_n, 3) && bus_grant_sync == $past(bus_grant_n, 3))
    else $error("bus pins not passed through");
  bus_hold_a: assert property (!async_arb_mode && !$past(core_clock_output) |->
      $stable(bus_busy_sync) && $stable(bus_grant_sync))
    else $error("bus pins moved while clock low");
endmodule

// ===== verification/pin_side_model.sv
// pin-side model: strap, nmi pin and bus handshake pins
`timescale 1ns/10ps
module pin_side_model (
  // control from bench
  input wire logic pclk,
  input wire logic fire,
  input wire logic strap,
  // pins
  output logic     pll_enable_strap,
  output logic     nmi_n,
  output logic     bus_busy_n,
  output logic     bus_grant_n
);
  logic [1:0] low_r = 2'h0;
  logic [1:0] cnt_r = 2'h0;
  assign pll_enable_strap = strap;
  assign nmi_n            = low_r == 2'h0;
  assign bus_busy_n       = cnt_r[0];
  assign bus_grant_n      = cnt_r[1];
  // nmi held low three cycles per request
  always_ff @(posedge pclk) begin
    low_r <= fire ? 2'h3 : low_r - {1'b0, low_r != 2'h0};
    cnt_r <= cnt_r + 2'h1;
  end
endmodule

// ===== verification/pll_clock_output_and_boot_control_tb_top.sv
// testbench top for the clock control block
`timescale 1ns/10ps
module pll_clock_output_and_boot_control_tb_top;
  import clkgen_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fire, strap;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pll_enable_strap, nmi_n, bus_busy_n, bus_grant_n, bus_busy_sync;
  logic        bus_grant_sync, core_clock_output, nmi_request, async_arb_mode, last_err;
  int          n_mismatch = 0;
  int          check_count = 0;
  pin_side_model pin_side_model_i (.*);
  pll_clock_ctrl pll_clock_ctrl_i (.*);
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang(input int k);
    if (k >= 20) begin
      n_mismatch++;
      $display("ERROR %0t wait ran out", $time);
      results();
    end
  endtask
  function automatic logic [31:0] ctl_exp(input logic on);
    return {8'h0, DIV_RST, MULT_RST, 7'h0, on};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    hang(k);
    q = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic int half_per(input logic [31:0] c);
    int p;
    p = 1;
    if (c[PLL_ON_POS] && c[MULT_LSB +: FACTOR_W] != 8'h00) begin
      p = int'(c[DIV_LSB +: FACTOR_W] / c[MULT_LSB +: FACTOR_W]);
    end
    return (p == 0) ? 1 : p;
  endfunction
  task automatic toggles(input int per);
    logic p;
    int   k;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    p = core_clock_output;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (core_clock_output === p && k < 20);
    hang(k);
    repeat (3) begin
      p = core_clock_output;
      repeat (per - 1) begin
        @(negedge pclk);
        chk(32'(core_clock_output), 32'(p));
      end
      @(negedge pclk);
      chk(32'(core_clock_output), 32'(!p));
    end
  endtask
  task automatic nmi_try;
    int k;
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (nmi_request !== 1'b1 && k < 20);
    hang(k);
    chk(32'(k), 32'(SYNC_STAGES + 2));
    @(negedge pclk);
    chk(32'(nmi_request), 32'h0);
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    logic [31:0] q, d;
    int          i;
    {presetn, psel, penable, pwrite, fire, strap} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    void'($urandom(16295));
    d = $urandom;
    for (i = 0; i < 2; i++) begin
      @(posedge pclk);
      strap   <= d[0] ^ i[0];
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, PLL_CONTROL_OFF, 32'h0, q);
      chk(q, ctl_exp(strap));
      toggles(1);
      $display("strap test %0d done", i);
    end
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      d[0] = i[0];
      apb(1'b1, MODE_CTRL_OFF, d, q);
      repeat (3) @(posedge pclk);
      chk(32'(async_arb_mode), 32'(d[0]));
      nmi_try();
    end
    apb(1'b0, NMI_COUNT_OFF, 32'h0, q);
    chk(q, 32'h4);
    apb(1'b0, STATUS_OFF, 32'h0, q);
    chk(q, {28'h0, 1'b1, strap, strap, 1'b1});
    apb(1'b1, STATUS_OFF, 32'h1, q);
    apb(1'b0, STATUS_OFF, 32'h0, q);
    chk(32'(q[NMI_PEND_POS]), 32'h0);
    $display("mode and nmi test done");
    apb(1'b0, PLL_CONTROL_OFF, 32'h0, q);
    chk(q, ctl_exp(strap));
    apb(1'b1, PLL_CONTROL_OFF, 32'h0001_0101, q);
    toggles(1);
    apb(1'b0, STATUS_OFF, 32'h0, q);
    chk(32'(q[ALIGN_REF_POS]), 32'h1);
    d = {8'h0, 8'($urandom_range(4, 1)), 8'($urandom_range(4, 1)), 8'h01};
    apb(1'b1, PLL_CONTROL_OFF, d, q);
    apb(1'b0, PLL_CONTROL_OFF, 32'h0, q);
    chk(q, d);
    toggles(half_per(d));
    apb(1'b1, PLL_CONTROL_OFF, 32'h0001_0100, q);
    toggles(half_per(32'h0001_0100));
    apb(1'b0, 12'h010, 32'h0, q);
    chk(q, 32'h0);
    chk(32'(last_err), 32'h1);
    $display("loop and map test done");
    results();
  end
endmodule
bind pll_clock_ctrl pll_clock_ctrl_monitor pll_clock_ctrl_monitor_i (.*);
